// >>> port_pkg.sv
// Constants and types shared by the memory pin front end
package port_pkg;

   localparam int ADDR_W        = 23;
   localparam int BANK_W        = 3;
   localparam int COL_W         = 3;
   localparam int IDX_W         = BANK_W + COL_W;
   localparam int MEM_WORDS     = 1 << IDX_W;
   localparam int DQ_W          = 36;
   localparam int HALF_W        = 18;
   localparam int NARROW_W      = 9;
   localparam int LANES         = 2;

   localparam int CFG_W         = 3;
   localparam int CFG_BURST_BIT = 0;
   localparam int CFG_WIDTH_LSB = 1;
   localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

   localparam logic [1:0] WIDTH_X36 = 2'h0;
   localparam logic [1:0] WIDTH_X18 = 2'h1;
   localparam logic [1:0] WIDTH_X9  = 2'h2;

   localparam logic [2:0] BURST_SHORT = 3'h2;
   localparam logic [2:0] BURST_LONG  = 3'h4;
   localparam logic [2:0] PAIR_BEATS  = 3'h2;
   localparam logic [2:0] ONE_BEAT    = 3'h1;
   localparam logic [COL_W-1:0] COL_STEP = 3'h1;
   localparam logic [COL_W-1:0] COL_PAIR = 3'h2;

   typedef enum logic [4:0] {
      CMD_NONE    = 5'h01,
      CMD_CONFIG  = 5'h02,
      CMD_WRITE   = 5'h04,
      CMD_REFRESH = 5'h08,
      CMD_READ    = 5'h10
   } command_type;

endpackage : port_pkg

// >>> write_capture.sv
// Double-edge write data capture on one write data clock pair
`timescale 1ns/1ps
module write_capture (
   input  wire logic                         write_data_clock,
   input  wire logic                         write_data_clock_n,
   input  wire logic                         rst,
   input  wire logic [port_pkg::HALF_W-1:0]  dq,
   input  wire logic                         write_mask,
   input  wire logic                         ack_toggle,
   output logic      [port_pkg::HALF_W-1:0]  pair_rise,
   output logic      [port_pkg::HALF_W-1:0]  pair_fall,
   output logic                              pair_mask_rise,
   output logic                              pair_mask_fall,
   output logic                              req_toggle
);

   logic [port_pkg::HALF_W-1:0] rise_q;
   logic [port_pkg::HALF_W-1:0] fall_q;
   logic                        mask_rise_q;
   logic                        mask_fall_q;
   logic                        rst_s1_q;
   logic                        rst_s2_q;
   logic                        ack_s1_q;
   logic                        ack_s2_q;

   // Rising edge beat
   always_ff @(posedge write_data_clock) begin
      rise_q      <= dq;
      mask_rise_q <= write_mask;
   end

   // Falling edge beat, taken on the complement's rising edge
   always_ff @(posedge write_data_clock_n) begin
      fall_q      <= dq;
      mask_fall_q <= write_mask;
   end

   // Reset and acknowledge synchronisers; clock must run for reset to land
   always_ff @(posedge write_data_clock) begin
      rst_s1_q <= rst;
      rst_s2_q <= rst_s1_q;
      ack_s1_q <= ack_toggle;
      ack_s2_q <= ack_s1_q;
   end

   // Hand a finished beat pair over when the last one was acknowledged
   always_ff @(posedge write_data_clock) begin
      if (rst_s2_q) begin
         req_toggle     <= 1'h0;
         pair_rise      <= '0;
         pair_fall      <= '0;
         pair_mask_rise <= 1'h0;
         pair_mask_fall <= 1'h0;
      end else if (req_toggle == ack_s2_q) begin
         pair_rise      <= rise_q;
         pair_fall      <= fall_q;
         pair_mask_rise <= mask_rise_q;
         pair_mask_fall <= mask_fall_q;
         req_toggle     <= ~req_toggle;
      end
   end

endmodule : write_capture

// >>> ddr_cmd_data_port.sv
// Command, address and data pin front end of a double-data-rate memory
`timescale 1ns/1ps
module ddr_cmd_data_port (
   input  wire logic                                  clock,
   input  wire logic                                  rst,
   input  wire logic                                  cs_n,
   input  wire logic                                  we_n,
   input  wire logic                                  ref_n,
   input  wire logic [port_pkg::ADDR_W-1:0]           address,
   input  wire logic [port_pkg::BANK_W-1:0]           bank,
   input  wire logic [port_pkg::LANES-1:0]            write_data_clock,
   input  wire logic [port_pkg::LANES-1:0]            write_data_clock_n,
   input  wire logic                                  write_mask,
   input  wire logic                                  termination_enable,
   input  wire logic [port_pkg::DQ_W-1:0]             dq_in,
   output logic      [port_pkg::DQ_W-1:0]             dq_out,
   output logic      [port_pkg::DQ_W-1:0]             dq_oe,
   output logic      [port_pkg::LANES-1:0]            read_data_clock,
   output logic      [port_pkg::LANES-1:0]            read_data_clock_n,
   output logic                                       read_valid
);

   port_pkg::command_type                          cmd;
   logic [port_pkg::CFG_W-1:0]                     config_q;
   logic [1:0]                                     width;
   logic                                           burst_long;
   logic [2:0]                                     burst_beats;
   logic [port_pkg::DQ_W-1:0]                      used_mask;

   logic                                           write_pend_q;
   logic [2:0]                                     write_left_q;
   logic [port_pkg::IDX_W-1:0]                     write_idx_q;
   logic [port_pkg::IDX_W-1:0]                     write_next_idx;
   logic                                           commit;
   logic                                           lanes_ready;
   logic                                           mask_rise;
   logic                                           mask_fall;

   logic [2:0]                                     read_left_q;
   logic [port_pkg::IDX_W-1:0]                     read_idx_q;
   logic                                           reading;

   logic                                           qk_q;
   logic                                           qk_n_q;
   logic [port_pkg::DQ_W-1:0]                      dq_out_q;
   logic [port_pkg::DQ_W-1:0]                      dq_oe_q;
   logic                                           read_valid_q;

   logic [port_pkg::DQ_W-1:0]                      mem [port_pkg::MEM_WORDS];

   logic [port_pkg::LANES-1:0][port_pkg::HALF_W-1:0] pair_rise;
   logic [port_pkg::LANES-1:0][port_pkg::HALF_W-1:0] pair_fall;
   logic [port_pkg::LANES-1:0][port_pkg::HALF_W-1:0] lane_rise_q;
   logic [port_pkg::LANES-1:0][port_pkg::HALF_W-1:0] lane_fall_q;
   logic [port_pkg::LANES-1:0]                     pair_mask_rise;
   logic [port_pkg::LANES-1:0]                     pair_mask_fall;
   logic [port_pkg::LANES-1:0]                     lane_mask_rise_q;
   logic [port_pkg::LANES-1:0]                     lane_mask_fall_q;
   logic [port_pkg::LANES-1:0]                     req_toggle;
   logic [port_pkg::LANES-1:0]                     ack_q;
   logic [port_pkg::LANES-1:0]                     take;
   logic [port_pkg::LANES-1:0]                     have_q;

   // Command decode from the pins at the rising edge
   function automatic port_pkg::command_type decode_command(
      input logic cs_n_i,
      input logic we_n_i,
      input logic ref_n_i
   );
      port_pkg::command_type c;
      c = port_pkg::CMD_NONE;
      if (!cs_n_i) begin
         unique case ({we_n_i, ref_n_i})
            2'h0: c = port_pkg::CMD_CONFIG;
            2'h1: c = port_pkg::CMD_WRITE;
            2'h2: c = port_pkg::CMD_REFRESH;
            2'h3: c = port_pkg::CMD_READ;
         endcase
      end
      return c;
   endfunction : decode_command

   // Forms a stored word from two lane halves for the active width
   function automatic logic [port_pkg::DQ_W-1:0] width_word(
      input logic [1:0]                  w,
      input logic [port_pkg::HALF_W-1:0] hi,
      input logic [port_pkg::HALF_W-1:0] lo
   );
      logic [port_pkg::DQ_W-1:0] word;
      word = {hi, lo};
      if (w == port_pkg::WIDTH_X18) begin
         word = {{port_pkg::HALF_W{1'h0}}, lo};
      end else if (w == port_pkg::WIDTH_X9) begin
         word = {{(port_pkg::DQ_W - port_pkg::NARROW_W){1'h0}}, lo[port_pkg::NARROW_W-1:0]};
      end
      return word;
   endfunction : width_word

   assign cmd = decode_command(cs_n, we_n, ref_n);

   assign width       = config_q[port_pkg::CFG_WIDTH_LSB +: 2];
   assign burst_long  = config_q[port_pkg::CFG_BURST_BIT];
   assign burst_beats = burst_long ? port_pkg::BURST_LONG : port_pkg::BURST_SHORT;
   assign used_mask   = width_word(width, '1, '1);
   assign reading     = (read_left_q != 3'h0);

   // Configuration load
   always_ff @(posedge clock) begin
      if (rst) begin
         config_q <= port_pkg::CFG_RESET;
      end else if (cmd == port_pkg::CMD_CONFIG) begin
         config_q <= address[port_pkg::CFG_W-1:0];
      end
   end

   // Write data lanes and their crossings
   for (genvar g = 0; g < port_pkg::LANES; g++) begin : g_lane
      logic req_s1_q;
      logic req_s2_q;

      write_capture u_capture (
         .write_data_clock   (write_data_clock[g]),
         .write_data_clock_n (write_data_clock_n[g]),
         .rst                (rst),
         .dq                 (dq_in[g*port_pkg::HALF_W +: port_pkg::HALF_W]),
         .write_mask         (write_mask),
         .ack_toggle         (ack_q[g]),
         .pair_rise          (pair_rise[g]),
         .pair_fall          (pair_fall[g]),
         .pair_mask_rise     (pair_mask_rise[g]),
         .pair_mask_fall     (pair_mask_fall[g]),
         .req_toggle         (req_toggle[g])
      );

      always_ff @(posedge clock) begin
         if (rst) begin
            req_s1_q <= 1'h0;
            req_s2_q <= 1'h0;
            ack_q[g] <= 1'h0;
         end else begin
            req_s1_q <= req_toggle[g];
            req_s2_q <= req_s1_q;
            ack_q[g] <= req_s2_q;
         end
      end

      assign take[g] = (req_s2_q != ack_q[g]);

      always_ff @(posedge clock) begin
         if (rst) begin
            lane_rise_q[g]      <= '0;
            lane_fall_q[g]      <= '0;
            lane_mask_rise_q[g] <= 1'h0;
            lane_mask_fall_q[g] <= 1'h0;
         end else if (take[g] && write_pend_q) begin
            lane_rise_q[g]      <= pair_rise[g];
            lane_fall_q[g]      <= pair_fall[g];
            lane_mask_rise_q[g] <= pair_mask_rise[g];
            lane_mask_fall_q[g] <= pair_mask_fall[g];
         end
      end

      // A fresh pair wins over the clear
      always_ff @(posedge clock) begin
         if (rst) begin
            have_q[g] <= 1'h0;
         end else if (take[g] && write_pend_q) begin
            have_q[g] <= 1'h1;
         end else if (commit || cmd == port_pkg::CMD_WRITE) begin
            have_q[g] <= 1'h0;
         end
      end
   end

   // Wide mode needs both lanes; narrow modes use the first pair only
   assign lanes_ready = (width == port_pkg::WIDTH_X36) ? (&have_q) : have_q[0];
   assign commit      = write_pend_q && lanes_ready;
   assign mask_rise   = (width == port_pkg::WIDTH_X36) ? lane_mask_rise_q[1]
                                                       : lane_mask_rise_q[0];
   assign mask_fall   = (width == port_pkg::WIDTH_X36) ? lane_mask_fall_q[1]
                                                       : lane_mask_fall_q[0];
   assign write_next_idx = {write_idx_q[port_pkg::IDX_W-1:port_pkg::COL_W],
                            write_idx_q[port_pkg::COL_W-1:0] + port_pkg::COL_STEP};

   // Write command and burst progress; in-flight bursts finish when disabled
   always_ff @(posedge clock) begin
      if (rst) begin
         write_pend_q <= 1'h0;
         write_left_q <= 3'h0;
         write_idx_q  <= '0;
      end else if (cmd == port_pkg::CMD_WRITE) begin
         write_pend_q <= 1'h1;
         write_left_q <= burst_beats;
         write_idx_q  <= {bank, address[port_pkg::COL_W-1:0]};
      end else if (commit) begin
         write_idx_q  <= {write_idx_q[port_pkg::IDX_W-1:port_pkg::COL_W],
                          write_idx_q[port_pkg::COL_W-1:0] + port_pkg::COL_PAIR};
         write_left_q <= write_left_q - port_pkg::PAIR_BEATS;
         write_pend_q <= (write_left_q > port_pkg::PAIR_BEATS);
      end
   end

   // Storage of the beat pair, masked beats skipped
   always_ff @(posedge clock) begin
      if (commit && !mask_rise) begin
         mem[write_idx_q] <= width_word(width, lane_rise_q[1], lane_rise_q[0]);
      end
      if (commit && !mask_fall) begin
         mem[write_next_idx] <= width_word(width, lane_fall_q[1], lane_fall_q[0]);
      end
   end

   // Read command and burst progress
   always_ff @(posedge clock) begin
      if (rst) begin
         read_left_q <= 3'h0;
         read_idx_q  <= '0;
      end else if (cmd == port_pkg::CMD_READ) begin
         read_left_q <= burst_beats;
         read_idx_q  <= {bank, address[port_pkg::COL_W-1:0]};
      end else if (reading) begin
         read_left_q <= read_left_q - port_pkg::ONE_BEAT;
         read_idx_q  <= {read_idx_q[port_pkg::IDX_W-1:port_pkg::COL_W],
                         read_idx_q[port_pkg::COL_W-1:0] + port_pkg::COL_STEP};
      end
   end

   // Read beat and valid launched on the same edge as a clock toggle
   always_ff @(posedge clock) begin
      if (rst) begin
         read_valid_q <= 1'h0;
         dq_out_q     <= '0;
      end else if (reading) begin
         read_valid_q <= 1'h1;
         dq_out_q     <= mem[read_idx_q] & used_mask;
      end else begin
         read_valid_q <= 1'h0;
         dq_out_q     <= '0;
      end
   end

   // Used pins drive during reads; unused pins float under termination
   always_ff @(posedge clock) begin
      if (rst) begin
         dq_oe_q <= '0;
      end else begin
         dq_oe_q <= (used_mask & {port_pkg::DQ_W{reading}})
                  | (~used_mask & {port_pkg::DQ_W{!termination_enable}});
      end
   end

   // Free-running read data clocks, one edge per beat
   always_ff @(posedge clock) begin
      if (rst) begin
         qk_q   <= 1'h0;
         qk_n_q <= 1'h1;
      end else begin
         qk_q   <= ~qk_q;
         qk_n_q <= ~qk_n_q;
      end
   end

   assign dq_out            = dq_out_q;
   assign dq_oe             = dq_oe_q;
   assign read_valid        = read_valid_q;
   assign read_data_clock   = {port_pkg::LANES{qk_q}};
   assign read_data_clock_n = {port_pkg::LANES{qk_n_q}};

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_short_read;
      cmd == port_pkg::CMD_READ && !burst_long;
   endsequence

   sequence s_two_beats;
      read_valid_q [*2];
   endsequence

   a_read_burst: assert property (s_short_read |=> ##1 s_two_beats)
      else $error("Short read did not give two valid beats");

   a_config_load: assert property (
      cmd == port_pkg::CMD_CONFIG |=> config_q == $past(address[port_pkg::CFG_W-1:0]))
      else $error("Configuration not taken from address");

   a_write_addr: assert property (
      cmd == port_pkg::CMD_WRITE
      |=> write_pend_q && write_idx_q == $past({bank, address[port_pkg::COL_W-1:0]}))
      else $error("Write address or bank not latched");

   a_cs_ignore: assert property (
      cs_n && !commit |=> $stable(config_q) && $stable(write_idx_q) && $stable(write_pend_q))
      else $error("Disabled decoder changed state");

   a_inflight_read: assert property (
      cs_n && reading |=> read_valid_q)
      else $error("Read in progress stopped while disabled");

   a_valid_window: assert property (
      read_valid_q == dq_oe_q[0] && (read_valid_q == $past(reading)))
      else $error("Read valid not matching driven data");

   a_clock_runs: assert property (
      !$past(rst) |-> qk_q != $past(qk_q) && qk_n_q == !qk_q)
      else $error("Read data clock not toggling");

   a_unused_float: assert property (
      termination_enable && $past(termination_enable) && width == port_pkg::WIDTH_X9
      && $past(width) == port_pkg::WIDTH_X9
      |-> dq_oe_q[port_pkg::DQ_W-1:port_pkg::NARROW_W] == '0)
      else $error("Unused data pin driven under termination");

   a_wide_commit: assert property (
      commit && width == port_pkg::WIDTH_X36 && !mask_rise
      |=> mem[$past(write_idx_q)] == $past({lane_rise_q[1], lane_rise_q[0]}))
      else $error("Wide write lanes not stored in their halves");

endmodule : ddr_cmd_data_port

// >>> ctrl_model.sv
// Memory controller model driving write data clocks, data and mask
`timescale 1ns/1ps
module ctrl_model (
   input  wire logic [port_pkg::DQ_W-1:0]  rise_word,
   input  wire logic [port_pkg::DQ_W-1:0]  fall_word,
   input  wire logic                       mask_rise,
   input  wire logic                       mask_fall,
   output logic      [port_pkg::LANES-1:0] write_data_clock,
   output logic      [port_pkg::LANES-1:0] write_data_clock_n,
   output logic      [port_pkg::DQ_W-1:0]  ctl_dq,
   output logic                            write_mask
);
   logic wclk;

   assign write_data_clock   = {port_pkg::LANES{wclk}};
   assign write_data_clock_n = {port_pkg::LANES{~wclk}};

   // Free-running clock; data set a quarter period before each edge
   initial begin
      wclk       = 1'b0;
      ctl_dq     = rise_word;
      write_mask = mask_rise;
      #13;
      forever begin
         wclk = 1'b1;
         #16;
         ctl_dq     = fall_word;
         write_mask = mask_fall;
         #16;
         wclk = 1'b0;
         #16;
         ctl_dq     = rise_word;
         write_mask = mask_rise;
         #16;
      end
   end
endmodule : ctrl_model

// >>> ddr_cmd_data_port_test.sv
// Self-checking bench for the memory pin front end
`timescale 1ns/1ps
module ddr_cmd_data_port_test;
   typedef struct {
      logic [2:0]  cfg;
      logic        term;
      logic [2:0]  bnk;
      logic [2:0]  col;
      logic [35:0] rw;
      logic [35:0] fw;
      logic        mr;
      logic        mf;
      logic [35:0] e0;
      logic [35:0] e1;
      logic [35:0] oe;
   } row_type;

   logic        clock = 1'b0;
   logic        rst = 1'b1;
   logic        cs_n = 1'b1;
   logic        we_n = 1'b1;
   logic        ref_n = 1'b1;
   logic [22:0] address = 23'h0;
   logic [2:0]  bank = 3'h0;
   logic        termination_enable = 1'b0;
   logic [35:0] rise_word = 36'h0;
   logic [35:0] fall_word = 36'h0;
   logic        mask_rise = 1'b0;
   logic        mask_fall = 1'b0;
   logic [1:0]  write_data_clock;
   logic [1:0]  write_data_clock_n;
   logic [35:0] ctl_dq;
   logic        write_mask;
   logic [35:0] dq_pin;
   logic [35:0] dq_out;
   logic [35:0] dq_oe;
   logic [1:0]  read_data_clock;
   logic [1:0]  read_data_clock_n;
   logic        read_valid;
   int          error_cnt = 0;
   int          check_count = 0;
   row_type     rows [4];

   // Pin level: device wins where it drives
   assign dq_pin = (dq_oe & dq_out) | (~dq_oe & ctl_dq);

   initial begin
      forever #50 clock = ~clock;
   end

   ctrl_model partner (
      .rise_word          (rise_word),
      .fall_word          (fall_word),
      .mask_rise          (mask_rise),
      .mask_fall          (mask_fall),
      .write_data_clock   (write_data_clock),
      .write_data_clock_n (write_data_clock_n),
      .ctl_dq             (ctl_dq),
      .write_mask         (write_mask)
   );

   ddr_cmd_data_port dut (
      .clock              (clock),
      .rst                (rst),
      .cs_n               (cs_n),
      .we_n               (we_n),
      .ref_n              (ref_n),
      .address            (address),
      .bank               (bank),
      .write_data_clock   (write_data_clock),
      .write_data_clock_n (write_data_clock_n),
      .write_mask         (write_mask),
      .termination_enable (termination_enable),
      .dq_in              (dq_pin),
      .dq_out             (dq_out),
      .dq_oe              (dq_oe),
      .read_data_clock    (read_data_clock),
      .read_data_clock_n  (read_data_clock_n),
      .read_valid         (read_valid)
   );

   task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit

   // Present pins for one edge, then return to idle with the read code and cs_n high
   task automatic cmd(input logic c, input logic w, input logic r, input logic [2:0] a,
                      input logic [2:0] b);
      @(posedge clock);
      cs_n    <= c;
      we_n    <= w;
      ref_n   <= r;
      address <= {20'h0, a};
      bank    <= b;
      @(posedge clock);
      cs_n    <= 1'b1;
      we_n    <= 1'b1;
      ref_n   <= 1'b1;
   endtask : cmd

   task automatic do_write(input logic [2:0] b, input logic [2:0] c);
      cmd(1'b0, 1'b0, 1'b1, c, b);
      repeat (20) @(posedge clock);
   endtask : do_write

   task automatic do_read(input logic [2:0] b, input logic [2:0] c, input int n,
                          input logic [35:0] e0, input logic [35:0] e1,
                          input logic [35:0] oe);
      logic prev;
      cmd(1'b0, 1'b1, 1'b1, c, b);
      #1;
      prev = read_data_clock[0];
      @(posedge clock);
      #1;
      for (int i = 0; i < n; i++) begin
         chk_bit(read_valid, 1'b1);
         chk_word(dq_out, (i % 2 == 0) ? e0 : e1);
         chk_word(dq_oe, oe);
         chk_bit(read_data_clock[0], ~prev);
         chk_bit(read_data_clock_n[1], ~read_data_clock[1]);
         prev = read_data_clock[0];
         @(posedge clock);
         #1;
      end
      chk_bit(read_valid, 1'b0);
      chk_word(dq_out, 36'h0);
   endtask : do_read

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : wrap_up

   initial begin
      #200000;
      error_cnt++;
      wrap_up();
   end

   initial begin
      rows[0] = '{3'h0, 1'b0, 3'h1, 3'h2, 36'h1_2345_6789, 36'h9_8765_4321, 1'b0, 1'b0,
                  36'h1_2345_6789, 36'h9_8765_4321, 36'hf_ffff_ffff};
      rows[1] = '{3'h2, 1'b1, 3'h7, 3'h7, 36'h5_5aa5_5aa5, 36'ha_a55a_a55a, 1'b0, 1'b0,
                  36'h0_0001_5aa5, 36'h0_0002_a55a, 36'h0_0003_ffff};
      rows[2] = '{3'h0, 1'b0, 3'h1, 3'h2, 36'hc_0ffe_e000, 36'h3_cafe_0001, 1'b1, 1'b0,
                  36'h1_2345_6789, 36'h3_cafe_0001, 36'hf_ffff_ffff};
      rows[3] = '{3'h4, 1'b1, 3'h1, 3'h2, 36'h7_0000_01c3, 36'h5_0000_0155, 1'b0, 1'b1,
                  36'h0_0000_01c3, 36'h0_0000_0001, 36'h0_0000_01ff};
      repeat (16) @(posedge clock);
      #1;
      chk_word(dq_out, 36'h0);
      chk_word(dq_oe, 36'h0);
      chk_bit(read_valid, 1'b0);
      chk_bit(read_data_clock[0], 1'b0);
      chk_bit(read_data_clock_n[0], 1'b1);
      @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      #1;
      chk_bit(read_data_clock[0], 1'b1);
      $display("reset test done");
      repeat (6) @(posedge clock);
      foreach (rows[i]) begin
         @(posedge clock);
         termination_enable <= rows[i].term;
         rise_word          <= rows[i].rw;
         fall_word          <= rows[i].fw;
         mask_rise          <= rows[i].mr;
         mask_fall          <= rows[i].mf;
         cmd(1'b0, 1'b0, 1'b0, rows[i].cfg, 3'h0);
         do_write(rows[i].bnk, rows[i].col);
         do_read(rows[i].bnk, rows[i].col, 2, rows[i].e0, rows[i].e1, rows[i].oe);
         $display("row %0d done", i);
      end
      // Long burst, decoder disabled with a read code while it runs
      @(posedge clock);
      termination_enable <= 1'b0;
      rise_word          <= 36'h8_1234_5678;
      fall_word          <= 36'h0_8765_4321;
      mask_rise          <= 1'b0;
      mask_fall          <= 1'b0;
      cmd(1'b0, 1'b0, 1'b0, 3'h1, 3'h0);
      do_write(3'h2, 3'h6);
      do_read(3'h2, 3'h6, 4, 36'h8_1234_5678, 36'h0_8765_4321, 36'hf_ffff_ffff);
      $display("long burst test done");
      // Refresh and a disabled-decoder read give no read data
      cmd(1'b1, 1'b1, 1'b1, 3'h2, 3'h2);
      cmd(1'b0, 1'b1, 1'b0, 3'h2, 3'h2);
      repeat (4) begin
         @(posedge clock);
         #1;
         chk_bit(read_valid, 1'b0);
      end
      $display("no command test done");
      wrap_up();
   end
endmodule : ddr_cmd_data_port_test
